/* inc/whpd_pkg.sv */
// Operation
// [RULE1] No strap resistors at power-up selects the ISA-style 16-bit host mode.
// [RULE2] ISA mode ignores address bit 0; even address selects offset half its value.
// [RULE3] ISA read of even offset: that byte low lane, next odd byte high lane.
// [RULE4] ISA read of odd offset: that same byte on both lanes.
// [RULE5] Register writes store only the low lane byte; high lane ignored.
// [RULE6] Read of offset 1E returns its byte on the low lane only.
// [RULE7] Read of offset 1F resets the device; a write stores the low byte.
// [RULE8] Offset 10, host address 20, is the programmed-I/O packet data port.
// [RULE9] Wide window aliasing the packet port spans 800 to FFF via line 11.
// [RULE10] The address line feeding window select places the wide window.
// [RULE11] Single reads and writes work at both packet port and wide window.
// [RULE12] Host issues bursts only through the wide window.
// [RULE13] Every window address returns successive packet words during bursts.
// [RULE14] Host addresses 40 to 7FF decode to nothing.
// [RULE15] Page 3 offset 0B bit 4 puts the internal regulator in standby.
// [RULE16] Pull-up strap mode: offset equals address; odd addresses write via high lane.
// [RULE17] Offset 11 is undefined: reads give any value, writes are ignored.
package whpd_pkg;
   // ************************************************
   // Register map and fields
   // ************************************************
   localparam int          OFS_W          = 5;
   localparam int          NUM_CSR        = 32;
   localparam logic [4:0]  OFS_CMD        = 5'h00;
   localparam logic [4:0]  OFS_PWR_MGMT   = 5'h0b;
   localparam logic [4:0]  OFS_DATA_PORT  = 5'h10;
   localparam logic [4:0]  OFS_UNDEF      = 5'h11;
   localparam logic [4:0]  OFS_LOW_ONLY   = 5'h1e;
   localparam logic [4:0]  OFS_RESET      = 5'h1f;
   localparam int          PAGE_HI_BIT    = 7;
   localparam int          PAGE_LO_BIT    = 6;
   localparam logic [1:0]  PWR_MGMT_PAGE  = 2'h3;
   localparam int          STANDBY_BIT    = 4;
   localparam logic [7:0]  PWR_MGMT_RESET_VAL = 8'h00;
   localparam logic [7:0]  CSR_RESET_VAL  = 8'h00;
   localparam logic [7:0]  UNDEF_BYTE     = 8'h00;
   localparam logic [15:0] UNMAPPED_WORD  = 16'h0000;

   // Bus modes picked by the straps
   typedef enum logic [1:0]
   {
      WHPD_MODE_ISA16 = 2'b00,
      WHPD_MODE_DIRECT = 2'b01,
      WHPD_MODE_OTHER = 2'b10
   } whpd_mode_e;

   typedef logic [7:0] whpd_byte_t;

   // Packet buffer write carrier
   typedef struct packed
   {
      logic        strobe;
      logic [15:0] data;
   } whpd_pkt_wr_s;

   // Whole module state
   typedef struct packed
   {
      whpd_byte_t [NUM_CSR-1:0] csr;
      logic [7:0]               power_management_ctrl;
      whpd_mode_e               mode;
      logic                     strap_done;
      logic [15:0]              rd_data;
      logic                     rd_valid;
      logic                     pkt_rd;
      whpd_pkt_wr_s             pkt_wr;
      logic                     dev_rst;
   } whpd_state_s;
endpackage

/* src/whpd_port.sv */
`timescale 1ns/1ps
module whpd_port
#(
   parameter int ADDR_W      = 12,
   parameter int WINDOW_LINE = 11
)
(
   input  wire logic                     SYS_CLK_IN,
   input  wire logic                     RST_IN,
   input  wire logic                     EEPROM_SELECT_STRAP_IN,
   input  wire logic                     EEPROM_CLOCK_STRAP_IN,
   input  wire logic [ADDR_W-1:0]        HOST_ADDR_IN,
   input  wire logic                     HOST_RD_IN,
   input  wire logic                     HOST_WR_IN,
   input  wire logic [15:0]              HOST_DATA_IN,
   output logic      [15:0]              HOST_DATA_OUT,
   output logic                          HOST_DATA_VALID_OUT,
   output logic                          PKT_RD_OUT,
   input  wire logic [15:0]              PKT_RD_DATA_IN,
   output whpd_pkg::whpd_pkt_wr_s        PKT_WR_OUT,
   output logic                          REGULATOR_STANDBY_OUT,
   output logic                          DEVICE_RESET_OUT,
   output whpd_pkg::whpd_mode_e          MODE_OUT
);
   import whpd_pkg::*;

   // ************************************************
   // State
   // ************************************************
   whpd_state_s      st;
   whpd_state_s      next_st;

   // ************************************************
   // Helpers
   // ************************************************
   // Byte seen by the host at an offset, page 3 steers 0B to power control
   function automatic logic [7:0] rd_byte(input whpd_state_s s, input logic [4:0] ofs);
      logic [7:0] b;
      b = s.csr[ofs];
      if (ofs == OFS_PWR_MGMT && s.csr[OFS_CMD][PAGE_HI_BIT:PAGE_LO_BIT] == PWR_MGMT_PAGE)
         b = s.power_management_ctrl;
      if (ofs == OFS_UNDEF)
         b = UNDEF_BYTE;
      return b;
   endfunction

   // ************************************************
   // Address decode
   // ************************************************
   logic             in_window;
   logic             unmapped;
   logic [4:0]       ofs;
   logic             odd;

   always_comb
   begin
      // [RULE10] window line placement
      in_window = HOST_ADDR_IN[WINDOW_LINE];
      unmapped  = 1'b0;
      ofs       = HOST_ADDR_IN[4:0];
      // [RULE2] ISA offset halving
      if (st.mode != WHPD_MODE_DIRECT)
      begin
         ofs = HOST_ADDR_IN[5:1];
      end
      // [RULE14] upper hole decodes nothing
      if (!in_window && st.mode != WHPD_MODE_DIRECT && HOST_ADDR_IN[WINDOW_LINE-1:6] != '0)
      begin
         unmapped = 1'b1;
      end
      if (!in_window && st.mode == WHPD_MODE_DIRECT && HOST_ADDR_IN[WINDOW_LINE-1:5] != '0)
      begin
         unmapped = 1'b1;
      end
      // [RULE9] window aliases packet port
      if (in_window)
      begin
         ofs = OFS_DATA_PORT;
      end
      odd = ofs[0];
   end

   // ************************************************
   // Next state
   // ************************************************
   always_comb
   begin
      next_st          = st;
      next_st.rd_valid = 1'b0;
      next_st.pkt_rd   = 1'b0;
      next_st.dev_rst  = 1'b0;
      next_st.pkt_wr.strobe = 1'b0;
      // [RULE1] strap capture after release
      if (!st.strap_done)
      begin
         next_st.strap_done = 1'b1;
         if (!EEPROM_SELECT_STRAP_IN && !EEPROM_CLOCK_STRAP_IN)
            next_st.mode = WHPD_MODE_ISA16;
         else if (!EEPROM_SELECT_STRAP_IN && EEPROM_CLOCK_STRAP_IN)
            next_st.mode = WHPD_MODE_DIRECT;
         else
            next_st.mode = WHPD_MODE_OTHER;
      end
      else if (HOST_RD_IN)
      begin
         next_st.rd_valid = 1'b1;
         next_st.rd_data  = UNMAPPED_WORD;
         if (unmapped)
         begin
            next_st.rd_data = UNMAPPED_WORD;
         end
         // [RULE8] packet port read, also [RULE11] [RULE13] every beat
         else if (ofs == OFS_DATA_PORT)
         begin
            next_st.pkt_rd  = 1'b1;
            next_st.rd_data = PKT_RD_DATA_IN;
         end
         // [RULE7] read of top offset resets
         else if (ofs == OFS_RESET)
         begin
            next_st.dev_rst = 1'b1;
            next_st.csr     = {NUM_CSR{CSR_RESET_VAL}};
            next_st.power_management_ctrl = PWR_MGMT_RESET_VAL;
            next_st.rd_data = UNMAPPED_WORD;
         end
         // [RULE6] low lane only
         else if (ofs == OFS_LOW_ONLY)
         begin
            next_st.rd_data = {8'h00, rd_byte(st, ofs)};
         end
         // [RULE16] direct mode pair read
         else if (st.mode == WHPD_MODE_DIRECT)
         begin
            next_st.rd_data = {rd_byte(st, {ofs[4:1], 1'b1}), rd_byte(st, {ofs[4:1], 1'b0})};
         end
         // [RULE4] odd byte on both lanes
         else if (odd)
         begin
            next_st.rd_data = {rd_byte(st, ofs), rd_byte(st, ofs)};
         end
         // [RULE3] even pair read
         else
         begin
            next_st.rd_data = {rd_byte(st, ofs | 5'h01), rd_byte(st, ofs)};
         end
      end
      else if (HOST_WR_IN && !unmapped)
      begin
         // [RULE8] packet port write
         if (ofs == OFS_DATA_PORT)
         begin
            next_st.pkt_wr.strobe = 1'b1;
            next_st.pkt_wr.data   = HOST_DATA_IN;
         end
         // [RULE17] undefined offset ignores writes
         else if (ofs == OFS_UNDEF)
         begin
            next_st.power_management_ctrl = st.power_management_ctrl;
         end
         // [RULE15] page 3 power control
         else if (ofs == OFS_PWR_MGMT && st.csr[OFS_CMD][PAGE_HI_BIT:PAGE_LO_BIT] == PWR_MGMT_PAGE)
         begin
            next_st.power_management_ctrl = (st.mode == WHPD_MODE_DIRECT && odd) ? HOST_DATA_IN[15:8]
                                                                                  : HOST_DATA_IN[7:0];
         end
         // [RULE16] odd address takes high lane
         else if (st.mode == WHPD_MODE_DIRECT && odd)
         begin
            next_st.csr[ofs] = HOST_DATA_IN[15:8];
         end
         // [RULE5] low lane store, [RULE7] write to 1F too
         else
         begin
            next_st.csr[ofs] = HOST_DATA_IN[7:0];
         end
      end
   end

   // ************************************************
   // Registers
   // ************************************************
   // State update, mode held through soft reset
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (RST_IN)
      begin
         st.csr        <= {NUM_CSR{CSR_RESET_VAL}};
         st.power_management_ctrl <= PWR_MGMT_RESET_VAL;
         st.mode       <= WHPD_MODE_ISA16;
         st.strap_done <= 1'b0;
         st.rd_data    <= 16'h0000;
         st.rd_valid   <= 1'b0;
         st.pkt_rd     <= 1'b0;
         st.pkt_wr     <= '0;
         st.dev_rst    <= 1'b0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ************************************************
   // Outputs
   // ************************************************
   // Data from flip-flops; packet read strobe is the live decode
   assign HOST_DATA_OUT         = st.rd_data;
   assign HOST_DATA_VALID_OUT   = st.rd_valid;
   assign PKT_RD_OUT            = st.strap_done && HOST_RD_IN && !unmapped && ofs == OFS_DATA_PORT;
   assign PKT_WR_OUT            = st.pkt_wr;
   assign REGULATOR_STANDBY_OUT = st.power_management_ctrl[STANDBY_BIT];
   assign DEVICE_RESET_OUT      = st.dev_rst;
   assign MODE_OUT              = st.mode;
endmodule

/* test/whpd_port_props.sv */
`timescale 1ns/1ps
module whpd_port_props
#(
   parameter int ADDR_W = 12
)
(
   input wire logic                 SYS_CLK_IN,
   input wire logic                 RST_IN,
   input wire logic [ADDR_W-1:0]    HOST_ADDR_IN,
   input wire logic                 HOST_RD_IN,
   input wire logic                 HOST_WR_IN,
   input wire logic [15:0]          HOST_DATA_IN,
   input wire logic [15:0]          HOST_DATA_OUT,
   input wire logic                 HOST_DATA_VALID_OUT,
   input wire logic                 PKT_RD_OUT,
   input wire logic [15:0]          PKT_RD_DATA_IN,
   input wire whpd_pkg::whpd_pkt_wr_s PKT_WR_OUT,
   input wire logic                 DEVICE_RESET_OUT,
   input wire whpd_pkg::whpd_mode_e MODE_OUT
);
   import whpd_pkg::*;
   // ***
   // Port checks
   // ***
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (RST_IN);
   // Decoded strobes
   wire direct = MODE_OUT == WHPD_MODE_DIRECT;
   wire win = HOST_ADDR_IN[11] || (direct ? HOST_ADDR_IN == 12'h010 : HOST_ADDR_IN[11:1] == 11'h010);
   wire top = direct ? HOST_ADDR_IN == 12'h01f : HOST_ADDR_IN[11:1] == 11'h01f;
   wire low = MODE_OUT == WHPD_MODE_ISA16 && !HOST_ADDR_IN[11];
   AST_RD_VALID: assert property (HOST_RD_IN |=> HOST_DATA_VALID_OUT)
      else $error("read not answered");
   AST_NO_VALID: assert property (!HOST_RD_IN |=> !HOST_DATA_VALID_OUT)
      else $error("spurious valid");
   AST_PKT_RD: assert property (HOST_RD_IN && win |-> PKT_RD_OUT)
      else $error("packet read missing");
   AST_PKT_DATA: assert property (HOST_RD_IN && win |=> HOST_DATA_OUT == $past(PKT_RD_DATA_IN))
      else $error("packet word wrong");
   AST_PKT_WR: assert property (HOST_WR_IN && !HOST_RD_IN && win
      |=> PKT_WR_OUT.strobe && PKT_WR_OUT.data == $past(HOST_DATA_IN))
      else $error("packet write wrong");
   AST_RESET: assert property (HOST_RD_IN && top |=> DEVICE_RESET_OUT)
      else $error("reset read ignored");
   AST_NO_RESET: assert property (!(HOST_RD_IN && top) |=> !DEVICE_RESET_OUT)
      else $error("spurious reset");
   AST_UNMAP: assert property (HOST_RD_IN && low && HOST_ADDR_IN[10:6] != 5'h00
      |=> HOST_DATA_OUT == 16'h0000)
      else $error("unmapped data");
   AST_ODD: assert property (HOST_RD_IN && low && HOST_ADDR_IN[10:6] == 5'h00 && HOST_ADDR_IN[1]
      |=> HOST_DATA_OUT[15:8] == HOST_DATA_OUT[7:0])
      else $error("odd lanes differ");
   AST_LOW_ONLY: assert property (HOST_RD_IN && low && HOST_ADDR_IN[10:1] == 10'h01e
      |=> HOST_DATA_OUT[15:8] == 8'h00)
      else $error("high lane not clear");
endmodule
bind whpd_port whpd_port_props #(.ADDR_W(ADDR_W)) u_props (.SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN),
   .HOST_ADDR_IN(HOST_ADDR_IN), .HOST_RD_IN(HOST_RD_IN), .HOST_WR_IN(HOST_WR_IN), .HOST_DATA_IN(HOST_DATA_IN),
   .HOST_DATA_OUT(HOST_DATA_OUT), .HOST_DATA_VALID_OUT(HOST_DATA_VALID_OUT), .PKT_RD_OUT(PKT_RD_OUT),
   .PKT_RD_DATA_IN(PKT_RD_DATA_IN), .PKT_WR_OUT(PKT_WR_OUT), .DEVICE_RESET_OUT(DEVICE_RESET_OUT),
   .MODE_OUT(MODE_OUT));

/* test/whpd_buf_model.sv */
`timescale 1ns/1ps
module whpd_buf_model
(
   input  wire logic        clk_in,
   input  wire logic        rd_in,
   output logic      [15:0] word_out
);
   // ***
   // Packet word source
   // ***
   initial word_out = 16'h1000;
   always @(posedge clk_in)
   begin
      if (rd_in)
         word_out <= word_out + 16'h0001;
   end
endmodule

/* test/wide_host_bus_port_decode_test.sv */
`timescale 1ns/1ps
module wide_host_bus_port_decode_test;
   import whpd_pkg::*;
   // ***
   // Bench
   // ***
   logic clk = 1'b0, rst = 1'b1, rd_r = 1'b0, wr_r = 1'b0, vld, prd, stby, drst;
   logic sel_strap = 1'b0, clk_strap = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [15:0] din = 16'h0000, dout, pword, w = 16'h1000;
   whpd_pkt_wr_s pwr;
   whpd_mode_e mode;
   int fails = 0, n_compared = 0;
   always #12.5 clk = ~clk;
   whpd_port dut (.SYS_CLK_IN(clk), .RST_IN(rst), .EEPROM_SELECT_STRAP_IN(sel_strap), .EEPROM_CLOCK_STRAP_IN(clk_strap),
      .HOST_ADDR_IN(addr), .HOST_RD_IN(rd_r), .HOST_WR_IN(wr_r), .HOST_DATA_IN(din), .HOST_DATA_OUT(dout),
      .HOST_DATA_VALID_OUT(vld), .PKT_RD_OUT(prd), .PKT_RD_DATA_IN(pword), .PKT_WR_OUT(pwr),
      .REGULATOR_STANDBY_OUT(stby), .DEVICE_RESET_OUT(drst), .MODE_OUT(mode));
   whpd_buf_model buf_m (.clk_in(clk), .rd_in(prd), .word_out(pword));
   task chk(input logic [15:0] s, input logic [15:0] e);
      n_compared++;
      if (s !== e)
      begin
         fails++;
         $display("Error %0t: got %h want %h", $time, s, e);
      end
   endtask
   task rd(input logic [11:0] a, input logic [15:0] e);
      @(negedge clk);
      addr = a;
      rd_r = 1'b1;
      @(negedge clk);
      rd_r = 1'b0;
      chk({15'h0, vld}, 16'h1);
      chk(dout, e);
   endtask
   task wr(input logic [11:0] a, input logic [15:0] d);
      @(negedge clk);
      addr = a;
      din = d;
      wr_r = 1'b1;
      @(negedge clk);
      wr_r = 1'b0;
   endtask
   task t_regs;
      chk(16'(mode), 16'(WHPD_MODE_ISA16));
      wr(12'h024, 16'hff12);
      wr(12'h026, 16'hee34);
      wr(12'h03c, 16'hdd56);
      rd(12'h024, 16'h3412);
      rd(12'h026, 16'h3434);
      rd(12'h03c, 16'h0056);
      wr(12'h025, 16'h0078);
      rd(12'h024, 16'h3478);
      $display("t_regs done");
   endtask
   task t_pwr;
      wr(12'h000, 16'h00c0);
      wr(12'h016, 16'h0010);
      @(negedge clk);
      chk({15'h0, stby}, 16'h1);
      wr(12'h016, 16'h00ef);
      @(negedge clk);
      chk({15'h0, stby}, 16'h0);
      $display("t_pwr done");
   endtask
   task t_port;
      wr(12'h020, 16'ha5c3);
      chk({15'h0, pwr.strobe}, 16'h1);
      chk(pwr.data, 16'ha5c3);
      wr(12'h9fe, 16'h5a3c);
      chk({15'h0, pwr.strobe}, 16'h1);
      chk(pwr.data, 16'h5a3c);
      rd(12'h020, w);
      w = w + 16'h1;
      rd(12'h802, w);
      w = w + 16'h1;
      @(negedge clk);
      for (int i = 0; i < 4; i++)
      begin
         addr = 12'h800 + 12'(i * 2);
         rd_r = 1'b1;
         @(negedge clk);
         chk({15'h0, vld}, 16'h1);
         chk(dout, w);
         w = w + 16'h1;
      end
      rd_r = 1'b0;
      $display("t_port done");
   endtask
   task t_unmap;
      wr(12'h040, 16'h1234);
      rd(12'h040, 16'h0000);
      rd(12'h000, 16'h00c0);
      rd(12'h7fe, 16'h0000);
      wr(12'h022, 16'h00aa);
      rd(12'h022, 16'h0000);
      $display("t_unmap done");
   endtask
   task t_reset;
      wr(12'h03e, 16'h0099);
      wr(12'h016, 16'h0010);
      chk({15'h0, stby}, 16'h1);
      rd(12'h03e, 16'h0000);
      chk({15'h0, drst}, 16'h1);
      chk({15'h0, stby}, 16'h0);
      repeat (2) @(negedge clk);
      rd(12'h024, 16'h0000);
      $display("t_reset done");
   endtask
   // Mid-run reset with clock strap pulled up
   task t_direct;
      @(negedge clk);
      rst = 1'b1;
      clk_strap = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      chk(16'(mode), 16'(WHPD_MODE_DIRECT));
      wr(12'h013, 16'h9a00);
      wr(12'h012, 16'h00bc);
      rd(12'h012, 16'h9abc);
      rd(12'h013, 16'h9abc);
      rd(12'h010, w);
      w = w + 16'h1;
      rd(12'h020, 16'h0000);
      $display("t_direct done");
   endtask
   task complete_run;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      t_regs;
      t_pwr;
      t_port;
      t_unmap;
      t_reset;
      t_direct;
      complete_run;
   end
endmodule
